// ---- logic/spmx_top.sv ----
// serial port and upper address pin mux with its selection register
// assumes peripherals on the same cpu clock and pins from outside
//
// Operation
// - port one code 00: card port one
// - port one 01: serial master; 11 reserved
// - port one 10: general i/o 11..6
// - port zero code 00: card port zero
// - port zero 01: audio plus gio 5..4
// - port zero 10: general i/o 5..0
// - port zero 11: buffered serial module
// - bits 7:6 read fixed, writes ignored
// - bit 5: address 20 or gio 26
// - bit 4: address 19 or gio 25
// - bit 3: address 18 or gio 24
// - bit 2: address 17 or gio 23
// - reset: address pins are gio inputs
// - ten cycles after reset, capture boot levels
// - field changes reroute pins next cycle
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none

module spmx_top (
  input  wire logic        clk_in,            // cpu clock, 25 MHz
  input  wire logic        resetn_in,         // system reset, active low
  // register port
  input  wire logic [15:0] reg_addr_in,       // register address
  input  wire logic [15:0] reg_wdata_in,      // write data
  input  wire logic        reg_wr_in,         // write strobe
  input  wire logic        reg_rd_in,         // read strobe
  output logic      [15:0] reg_rdata_out,     // read data, cycle after strobe
  // serial port one pins
  input  wire logic [5:0]  sp1_pin_in,        // pin levels
  output logic      [5:0]  sp1_pin_out,       // pin drive values
  output logic      [5:0]  sp1_pin_oe_n_out,  // low while driving
  // serial port zero pins
  input  wire logic [5:0]  sp0_pin_in,        // pin levels
  output logic      [5:0]  sp0_pin_out,       // pin drive values
  output logic      [5:0]  sp0_pin_oe_n_out,  // low while driving
  // upper address pins, bit 0 is address 17
  input  wire logic [3:0]  addr_pin_in,       // pin levels
  output logic      [3:0]  addr_pin_out,      // pin drive values
  output logic      [3:0]  addr_pin_oe_n_out, // low while driving
  // card_port_one
  input  wire logic [5:0]  card1_out_in,      // values to drive
  input  wire logic [5:0]  card1_oe_n_in,     // low to drive
  output logic      [5:0]  card1_in_out,      // pin levels back
  // multichannel_serial_master
  input  wire logic [5:0]  mcsm_out_in,       // values to drive
  input  wire logic [5:0]  mcsm_oe_n_in,      // low to drive
  output logic      [5:0]  mcsm_in_out,       // pin levels back
  // card_port_zero
  input  wire logic [5:0]  card0_out_in,      // values to drive
  input  wire logic [5:0]  card0_oe_n_in,     // low to drive
  output logic      [5:0]  card0_in_out,      // pin levels back
  // audio_serial_zero
  input  wire logic [3:0]  aud0_out_in,       // values to drive
  input  wire logic [3:0]  aud0_oe_n_in,      // low to drive
  output logic      [3:0]  aud0_in_out,       // pin levels back
  // buffered_multichannel_serial
  input  wire logic [5:0]  bms_out_in,        // values to drive
  input  wire logic [5:0]  bms_oe_n_in,       // low to drive
  output logic      [5:0]  bms_in_out,        // pin levels back
  // general_io_line 26..0
  input  wire logic [26:0] gio_out_in,        // values to drive
  input  wire logic [26:0] gio_oe_n_in,       // low to drive
  output logic      [26:0] gio_in_out,        // pin levels back
  // memory_address_out 20..17 from the memory interface
  input  wire logic [3:0]  mem_addr_in,       // address bits 20..17
  // status
  output logic      [3:0]  boot_level_out,    // captured boot levels
  output logic             boot_valid_out     // capture has happened
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release synchroniser
  logic rst_meta_q; // first stage, read only by the second
  logic rst_n_q;    // reset used by the rest of the block

  // assert at once, release after two edges
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // six-wide four-way pick, used for drive, enable and both ports
  function automatic logic [5:0] pick6(
    input logic [1:0] mode,
    input logic [5:0] c0,
    input logic [5:0] c1,
    input logic [5:0] c2,
    input logic [5:0] c3
  );
    case (mode)
      spmx_pkg::SP_ROUTE_CARD: pick6 = c0;
      spmx_pkg::SP_ROUTE_ALT:  pick6 = c1;
      spmx_pkg::SP_ROUTE_GIO:  pick6 = c2;
      default:                 pick6 = c3;
    endcase
  endfunction

  // level back to a peripheral only while it owns the pins
  function automatic logic [5:0] give6(
    input logic [1:0] mode,
    input logic [1:0] owner,
    input logic [5:0] lvl
  );
    give6 = (mode == owner) ? lvl : 6'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // selection register state
  logic [1:0] sp1_route_q;   // serial_port_one_route
  logic [1:0] sp0_route_q;   // serial_port_zero_route
  logic [3:0] addr_func_q;   // addr_pin20..17_function, 1 = gio
  logic [3:0] boot_level_q;  // captured boot levels
  logic [3:0] boot_cnt_q;    // cycles since reset release
  logic [3:0] boot_cnt_d;    // next count
  logic [15:0] rdata_q;      // read data, held for one cycle

  spmx_pkg::spmx_boot_e boot_state_q; // boot capture state
  spmx_pkg::spmx_boot_e boot_state_d; // next boot state

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire        sel_hit   = (reg_addr_in == spmx_pkg::SEL_OFFSET);  // selection reg
  wire        boot_hit  = (reg_addr_in == spmx_pkg::BOOT_OFFSET); // boot reg
  wire        sel_wr    = reg_wr_in & sel_hit;                    // selection write
  wire [1:0]  sp1_wdata = reg_wdata_in[spmx_pkg::SP1_LSB +: 2];   // new port one code
  wire [1:0]  sp0_wdata = reg_wdata_in[spmx_pkg::SP0_LSB +: 2];   // new port zero code
  wire [3:0]  addr_wdata = reg_wdata_in[spmx_pkg::ADDR_MODE_LSB +: 4]; // new pin modes

  // selection register image; bits outside this block read as zero
  wire [15:0] sel_image = {4'h0,
                           sp1_route_q,
                           sp0_route_q,
                           spmx_pkg::RSVD_VAL,
                           addr_func_q,
                           2'h0};
  // boot register image, captured levels in the low bits
  wire [15:0] boot_image = {12'h000, boot_level_q};
  // read mux, unmapped offsets answer zero
  wire [15:0] rd_mux = sel_hit  ? sel_image  :
                       boot_hit ? boot_image : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // selection register writes; reserved bits are never stored
  // pin routing reads these flops directly, so a write reroutes next cycle
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sp1_route_q <= spmx_pkg::SP1_RST;
      sp0_route_q <= spmx_pkg::SP0_RST;
      addr_func_q <= spmx_pkg::ADDR_MODE_RST;
    end else if (sel_wr) begin
      sp1_route_q <= sp1_wdata;
      sp0_route_q <= sp0_wdata;
      addr_func_q <= addr_wdata;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= reg_rd_in ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata_out = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin level synchronisers
  // every pin is outside the clock domain, so levels pass two flops
  // before they reach a peripheral or the boot capture
  spmx_sync_if #(.W(16)) pin_sync ();

  assign pin_sync.raw = {addr_pin_in, sp0_pin_in, sp1_pin_in};

  spmx_pin_sync #(
    .W (16)
  ) u_pin_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_q),
    .port     (pin_sync)
  );

  wire [5:0] sp1_lvl  = pin_sync.sync[5:0];   // port one levels
  wire [5:0] sp0_lvl  = pin_sync.sync[11:6];  // port zero levels
  wire [3:0] addr_lvl = pin_sync.sync[15:12]; // address pin levels

  ////////////////////////////////////////////////////////////////////////////
  // boot level capture
  // counts from the release of the synchronised reset; the pin levels
  // seen here are two cycles old, well inside the settle time
  wire boot_hit_cnt = (boot_cnt_q == spmx_pkg::BOOT_DELAY_CYC); // ten cycles

  // next state and count
  always_comb begin
    boot_state_d = boot_state_q;
    boot_cnt_d   = boot_cnt_q;
    case (boot_state_q)
      spmx_pkg::BOOT_WAIT: begin
        if (boot_hit_cnt) begin
          boot_state_d = spmx_pkg::BOOT_DONE;
        end else begin
          boot_cnt_d = boot_cnt_q + 4'h1;
        end
      end
      spmx_pkg::BOOT_DONE: begin
        boot_state_d = spmx_pkg::BOOT_DONE; // holds until next reset
      end
      default: begin
        boot_state_d = spmx_pkg::BOOT_WAIT;
        boot_cnt_d   = 4'h0;
      end
    endcase
  end

  // state, count and capture flops
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      boot_state_q <= spmx_pkg::BOOT_WAIT;
      boot_cnt_q   <= 4'h0;
      boot_level_q <= spmx_pkg::BOOT_RST;
    end else begin
      boot_state_q <= boot_state_d;
      boot_cnt_q   <= boot_cnt_d;
      if ((boot_state_q == spmx_pkg::BOOT_WAIT) && boot_hit_cnt) begin
        boot_level_q <= addr_lvl;
      end
    end
  end

  assign boot_level_out = boot_level_q;
  assign boot_valid_out = (boot_state_q == spmx_pkg::BOOT_DONE);

  ////////////////////////////////////////////////////////////////////////////
  // serial port one routing
  // the reserved code drives nothing, so a bad write cannot fight a pin;
  // software still has to gate and reset the peripherals around a change
  wire [5:0] gio11_6_out  = gio_out_in[spmx_pkg::SP1_GIO_LSB +: 6];  // gio 11..6
  wire [5:0] gio11_6_oen  = gio_oe_n_in[spmx_pkg::SP1_GIO_LSB +: 6]; // gio 11..6

  assign sp1_pin_out = pick6(sp1_route_q,
                             card1_out_in,
                             mcsm_out_in,
                             gio11_6_out,
                             6'h00);
  assign sp1_pin_oe_n_out = pick6(sp1_route_q,
                                  card1_oe_n_in,
                                  mcsm_oe_n_in,
                                  gio11_6_oen,
                                  6'h3f);

  // levels back to the owner of port one
  assign card1_in_out = give6(sp1_route_q, spmx_pkg::SP_ROUTE_CARD, sp1_lvl);
  assign mcsm_in_out  = give6(sp1_route_q, spmx_pkg::SP_ROUTE_ALT, sp1_lvl);
  wire [5:0] sp1_gio_in = give6(sp1_route_q, spmx_pkg::SP_ROUTE_GIO, sp1_lvl);

  ////////////////////////////////////////////////////////////////////////////
  // serial port zero routing
  // mode 01 puts audio on the low four pins and gio 5..4 on the top two
  wire [5:0] gio5_0_out = gio_out_in[spmx_pkg::SP0_GIO_LSB +: 6];  // gio 5..0
  wire [5:0] gio5_0_oen = gio_oe_n_in[spmx_pkg::SP0_GIO_LSB +: 6]; // gio 5..0
  wire [5:0] aud_mix_out = {gio5_0_out[5:4], aud0_out_in};         // audio + gio
  wire [5:0] aud_mix_oen = {gio5_0_oen[5:4], aud0_oe_n_in};        // audio + gio

  assign sp0_pin_out = pick6(sp0_route_q,
                             card0_out_in,
                             aud_mix_out,
                             gio5_0_out,
                             bms_out_in);
  assign sp0_pin_oe_n_out = pick6(sp0_route_q,
                                  card0_oe_n_in,
                                  aud_mix_oen,
                                  gio5_0_oen,
                                  bms_oe_n_in);

  // levels back to the owner of port zero
  assign card0_in_out = give6(sp0_route_q, spmx_pkg::SP_ROUTE_CARD, sp0_lvl);
  assign bms_in_out   = give6(sp0_route_q, spmx_pkg::SP_ROUTE_AUX, sp0_lvl);
  wire [5:0] sp0_aud_lvl = give6(sp0_route_q, spmx_pkg::SP_ROUTE_ALT, sp0_lvl);
  assign aud0_in_out = sp0_aud_lvl[3:0];
  // gio 5..0 see the pins in mode 10, gio 5..4 also in mode 01
  wire [5:0] sp0_gio_in = give6(sp0_route_q, spmx_pkg::SP_ROUTE_GIO, sp0_lvl) |
                          {sp0_aud_lvl[5:4], 4'h0};

  ////////////////////////////////////////////////////////////////////////////
  // upper address pins, one slice per pin
  // until the boot levels are taken the pins in gio function are held as inputs, so a
  // gio block that comes out of reset driving cannot spoil the capture
  wire [3:0] addr_gio_in; // levels back to gio 26..23
  wire       boot_quiet = (boot_state_q != spmx_pkg::BOOT_DONE); // before capture

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_addr
      // gio owns the pin when its function flag is set
      wire as_gio = addr_func_q[gi];
      wire g_out  = gio_out_in[spmx_pkg::ADDR_GIO_LSB + gi];   // gio drive value
      wire g_oen  = gio_oe_n_in[spmx_pkg::ADDR_GIO_LSB + gi];  // gio drive enable
      assign addr_pin_out[gi] = as_gio ? g_out : mem_addr_in[gi];
      // address is always driven; gio pin is an input during boot
      assign addr_pin_oe_n_out[gi] = as_gio ? (g_oen | boot_quiet) : 1'b0;
      assign addr_gio_in[gi] = as_gio & addr_lvl[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // levels back to the general i/o block; lines not muxed here read zero
  assign gio_in_out = {addr_gio_in,      // gio 26..23
                       11'h000,          // gio 22..12, not muxed here
                       sp1_gio_in,       // gio 11..6
                       sp0_gio_in};      // gio 5..0

endmodule // spmx_top

`default_nettype wire

// ---- logic/spmx_pkg.sv ----
// constants shared by the serial port and address pin mux block
// assumes a 16-bit register port and a single cpu clock domain
`default_nettype none

package spmx_pkg;

  // register port widths
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  // register offsets on the plain register port
  localparam logic [15:0] SEL_OFFSET  = 16'h1c00; // external_bus_pin_select
  localparam logic [15:0] BOOT_OFFSET = 16'h1c01; // boot method capture, read only

  // field positions inside external_bus_pin_select
  localparam int unsigned SP1_LSB       = 10; // serial_port_one_route, bits 11:10
  localparam int unsigned SP0_LSB       = 8;  // serial_port_zero_route, bits 9:8
  localparam int unsigned RSVD_LSB      = 6;  // reserved, bits 7:6
  localparam int unsigned ADDR_MODE_LSB = 2;  // addr_pin17..20_function, bits 5:2

  // values after reset
  localparam logic [1:0] SP1_RST       = 2'h0;
  localparam logic [1:0] SP0_RST       = 2'h0;
  localparam logic [1:0] RSVD_VAL      = 2'h0;
  localparam logic [3:0] ADDR_MODE_RST = 4'hf; // all four pins general i/o
  localparam logic [3:0] BOOT_RST      = 4'h0;

  // cycles from reset release to boot level capture
  localparam logic [3:0] BOOT_DELAY_CYC = 4'ha;

  // pin group sizes
  localparam int unsigned PORT_W     = 6;  // pins per serial port
  localparam int unsigned ADDR_PINS  = 4;  // memory address 20..17
  localparam int unsigned GIO_W      = 27; // general_io_line 26..0
  localparam int unsigned ADDR_GIO_LSB = 23; // general_io_line 23..26 on addr pins
  localparam int unsigned SP1_GIO_LSB  = 6;  // general_io_line 11..6
  localparam int unsigned SP0_GIO_LSB  = 0;  // general_io_line 5..0

  // serial port route codes
  typedef enum logic [1:0] {
    SP_ROUTE_CARD = 2'b00, // card port module
    SP_ROUTE_ALT  = 2'b01, // serial master / audio+gio
    SP_ROUTE_GIO  = 2'b10, // general i/o lines
    SP_ROUTE_AUX  = 2'b11  // buffered serial, or reserved on port one
  } spmx_route_e;

  // boot capture sequence
  typedef enum logic [1:0] {
    BOOT_WAIT = 2'b00, // counting after reset release
    BOOT_DONE = 2'b01  // levels captured
  } spmx_boot_e;

endpackage : spmx_pkg

`default_nettype wire

// ---- logic/spmx_sync_if.sv ----
// interface carrying pin levels into and out of the synchroniser
// assumes both ends sit on the same cpu clock
`timescale 1ns/100ps
`default_nettype none

interface spmx_sync_if #(
  parameter int unsigned W = 16
);
  logic [W-1:0] raw;  // asynchronous pin levels
  logic [W-1:0] sync; // levels after two flops

  modport user (output raw, input sync);
  modport syncr (input raw, output sync);
endinterface : spmx_sync_if

`default_nettype wire

// ---- logic/spmx_pin_sync.sv ----
// two flop synchroniser for the pin levels read by the mux
// assumes the reset given is already synchronous on release
`timescale 1ns/100ps
`default_nettype none

module spmx_pin_sync #(
  parameter int unsigned W = 16
) (
  input  wire logic clk_in,   // cpu clock
  input  wire logic rst_n_in, // synchronised reset, active low
  spmx_sync_if.syncr port     // raw in, synchronised out
);

  ////////////////////////////////////////////////////////////////////////////
  // first stage only feeds the second stage, nothing else looks at it
  logic [W-1:0] meta_q;   // first stage
  logic [W-1:0] stable_q; // second stage

  // sample and resample
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q   <= '0;
      stable_q <= '0;
    end else begin
      meta_q   <= port.raw;
      stable_q <= meta_q;
    end
  end

  assign port.sync = stable_q;

endmodule // spmx_pin_sync

`default_nettype wire

// ---- sim/spmx_props.sv ----
// checker for the serial port and address pin mux, bound to spmx_top
// assumes writes and reads are single strobes on the plain register port
`timescale 1ns/100ps
`default_nettype none

module spmx_props (
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [5:0]  sp1_pin_out,
  input wire logic [5:0]  sp1_pin_oe_n_out,
  input wire logic [5:0]  sp0_pin_out,
  input wire logic [3:0]  addr_pin_out,
  input wire logic [3:0]  addr_pin_oe_n_out,
  input wire logic [5:0]  card1_out_in,
  input wire logic [5:0]  mcsm_out_in,
  input wire logic [5:0]  card0_out_in,
  input wire logic [3:0]  aud0_out_in,
  input wire logic [5:0]  bms_out_in,
  input wire logic [26:0] gio_out_in,
  input wire logic [3:0]  mem_addr_in,
  input wire logic        boot_valid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  ////////////////////
  // shadow of the selection register, implemented bits only
  logic [15:0] sel_q;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) sel_q <= 16'h003c;
    else if (reg_wr_in && reg_addr_in == spmx_pkg::SEL_OFFSET) sel_q <= reg_wdata_in & 16'h0f3c;
  end
  ////////////////////
  property p_sp1_card; sel_q[11:10] == 2'h0 |-> sp1_pin_out == card1_out_in; endproperty
  a_sp1_card: assert property (p_sp1_card) else $error("port one card");
  property p_sp1_mcsm; sel_q[11:10] == 2'h1 |-> sp1_pin_out == mcsm_out_in; endproperty
  a_sp1_mcsm: assert property (p_sp1_mcsm) else $error("port one serial");
  property p_sp1_rsvd; sel_q[11:10] == 2'h3 |-> sp1_pin_oe_n_out == 6'h3f; endproperty
  a_sp1_rsvd: assert property (p_sp1_rsvd) else $error("port one reserved");
  property p_sp1_gio; sel_q[11:10] == 2'h2 |-> sp1_pin_out == gio_out_in[11:6]; endproperty
  a_sp1_gio: assert property (p_sp1_gio) else $error("port one gio");
  property p_sp0_card; sel_q[9:8] == 2'h0 |-> sp0_pin_out == card0_out_in; endproperty
  a_sp0_card: assert property (p_sp0_card) else $error("port zero card");
  property p_sp0_aud;
    sel_q[9:8] == 2'h1 |-> sp0_pin_out == {gio_out_in[5:4], aud0_out_in};
  endproperty
  a_sp0_aud: assert property (p_sp0_aud) else $error("port zero audio");
  property p_sp0_gio; sel_q[9:8] == 2'h2 |-> sp0_pin_out == gio_out_in[5:0]; endproperty
  a_sp0_gio: assert property (p_sp0_gio) else $error("port zero gio");
  property p_sp0_bms; sel_q[9:8] == 2'h3 |-> sp0_pin_out == bms_out_in; endproperty
  a_sp0_bms: assert property (p_sp0_bms) else $error("port zero buffered");
  property p_rdata;
    reg_rd_in && reg_addr_in == spmx_pkg::SEL_OFFSET |=> reg_rdata_out == $past(sel_q);
  endproperty
  a_rdata: assert property (p_rdata) else $error("selection read");
  property p_addr_fn;
    ((addr_pin_out ^ mem_addr_in) & ~sel_q[5:2]) == 4'h0 &&
    (addr_pin_oe_n_out & ~sel_q[5:2]) == 4'h0 &&
    ((addr_pin_out ^ gio_out_in[26:23]) & sel_q[5:2]) == 4'h0;
  endproperty
  a_addr_fn: assert property (p_addr_fn) else $error("address pin function");
  property p_addr_in;
    !boot_valid_out && sel_q[5:2] == 4'hf |-> addr_pin_oe_n_out == 4'hf;
  endproperty
  a_addr_in: assert property (p_addr_in) else $error("address pin driven early");
  property p_boot; $rose(resetn_in) |-> !boot_valid_out [*8] ##[1:8] boot_valid_out; endproperty
  a_boot: assert property (p_boot) else $error("boot capture timing");
  // main scenarios reached
  c_wr: cover property (reg_wr_in && reg_addr_in == spmx_pkg::SEL_OFFSET);
  c_bms: cover property (sel_q[9:8] == 2'h3);
  c_boot: cover property ($rose(boot_valid_out));
endmodule // spmx_props

bind spmx_top spmx_props chk_u (.*);

`default_nettype wire

// ---- sim/spmx_periph_model.sv ----
// model of the internal peripherals feeding the pin mux
// assumes the bench hands it a fresh random word every cycle
`timescale 1ns/100ps
`default_nettype none

module spmx_periph_model (
  input  wire logic        clk_in,  // cpu clock
  input  wire logic        gate_in, // high: peripheral clocks stopped
  input  wire logic [31:0] seed_in, // random word from the bench
  output logic      [58:0] drv_out, // values of every peripheral
  output logic      [54:0] oen_out  // enables, low to drive
);
  initial begin
    drv_out = '0;
    oen_out = '1;
  end
  // a gated unit holds still while the routing changes
  always @(posedge clk_in) begin
    if (!gate_in) begin
      drv_out <= {seed_in, seed_in[26:0]};
      oen_out <= {seed_in[22:0], ~seed_in};
    end
  end
endmodule // spmx_periph_model

`default_nettype wire

// ---- sim/spmx_tb_top.sv ----
// self-checking bench for the serial port and address pin mux
// assumes spmx_props is bound to the design from its own file
`timescale 1ns/100ps
`default_nettype none

module spmx_tb_top;
  logic        clk_in, resetn_in, reg_wr_in, reg_rd_in, boot_valid_out, gate_q;
  logic [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out, ext_q, w, d, ph1, ph2;
  logic [5:0]  sp1_pin_in, sp1_pin_out, sp1_pin_oe_n_out, sp0_pin_in, sp0_pin_out;
  logic [5:0]  sp0_pin_oe_n_out, card1_out_in, card1_oe_n_in, card1_in_out, mcsm_out_in;
  logic [5:0]  mcsm_oe_n_in, mcsm_in_out, card0_out_in, card0_oe_n_in, card0_in_out;
  logic [5:0]  bms_out_in, bms_oe_n_in, bms_in_out;
  logic [3:0]  addr_pin_in, addr_pin_out, addr_pin_oe_n_out, aud0_out_in, aud0_oe_n_in;
  logic [3:0]  aud0_in_out, mem_addr_in, boot_level_out;
  logic [26:0] gio_out_in, gio_oe_n_in, gio_in_out;
  logic [31:0] rnd_q;
  logic [58:0] drv;
  logic [54:0] oen;
  int          n_errors, checks_done, sel_m, cnt;
  ////////////////////
  assign {card1_out_in, mcsm_out_in, card0_out_in, aud0_out_in, bms_out_in, gio_out_in,
          mem_addr_in} = drv;
  assign {card1_oe_n_in, mcsm_oe_n_in, card0_oe_n_in, aud0_oe_n_in, bms_oe_n_in,
          gio_oe_n_in} = oen;
  // pin wires: the device drive wins, else the outside level
  assign sp1_pin_in = (sp1_pin_out & ~sp1_pin_oe_n_out) | (ext_q[5:0] & sp1_pin_oe_n_out);
  assign sp0_pin_in = (sp0_pin_out & ~sp0_pin_oe_n_out) | (ext_q[11:6] & sp0_pin_oe_n_out);
  assign addr_pin_in = (addr_pin_out & ~addr_pin_oe_n_out) | (ext_q[15:12] & addr_pin_oe_n_out);
  spmx_top dut_u (.*);
  // pin levels as the two synchroniser stages hold them
  always @(posedge clk_in) {ph2, ph1} <= {ph1, addr_pin_in, sp0_pin_in, sp1_pin_in};
  spmx_periph_model per_u (.clk_in, .gate_in(gate_q), .seed_in(rnd_q), .drv_out(drv),
    .oen_out(oen));
  ////////////////////
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clk_in) rnd_q <= lfsr(rnd_q);
  // expected pins from the model register: port one, port zero, address
  function automatic logic [31:0] exp_pins(input int s);
    logic [5:0] o1, e1, o0, e0;
    logic [3:0] ao, ae;
    case (s[11:10])
      2'h0: {o1, e1} = {card1_out_in, card1_oe_n_in};
      2'h1: {o1, e1} = {mcsm_out_in, mcsm_oe_n_in};
      2'h2: {o1, e1} = {gio_out_in[11:6], gio_oe_n_in[11:6]};
      default: {o1, e1} = {6'h00, 6'h3f}; // reserved code drives nothing
    endcase
    case (s[9:8])
      2'h0: {o0, e0} = {card0_out_in, card0_oe_n_in};
      2'h1: {o0, e0} = {gio_out_in[5:4], aud0_out_in, gio_oe_n_in[5:4], aud0_oe_n_in};
      2'h2: {o0, e0} = {gio_out_in[5:0], gio_oe_n_in[5:0]};
      default: {o0, e0} = {bms_out_in, bms_oe_n_in};
    endcase
    for (int k = 0; k < 4; k++) begin
      ao[k] = s[2 + k] ? gio_out_in[23 + k] : mem_addr_in[k];
      ae[k] = s[2 + k] & gio_oe_n_in[23 + k];
    end
    return {o1, e1, o0, e0, ao, ae};
  endfunction
  // expected levels back to each owner, from pins two edges old
  function automatic logic [54:0] exp_lvl(input int s, input logic [15:0] p);
    logic [1:0] r1, r0;
    r1 = s[11:10];
    r0 = s[9:8];
    return {p[5:0] & {6{r1 == 2'h0}}, p[5:0] & {6{r1 == 2'h1}}, p[11:6] & {6{r0 == 2'h0}},
      p[9:6] & {4{r0 == 2'h1}}, p[11:6] & {6{r0 == 2'h3}}, p[15:12] & s[5:2], 11'h0,
      p[5:0] & {6{r1 == 2'h2}}, p[11:10] & {2{r0[1] ^ r0[0]}}, p[9:6] & {4{r0 == 2'h2}}};
  endfunction
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t pins got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    if (a == 16'h1c00) sel_m = v & 16'h0f3c;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    v = reg_rdata_out;
  endtask
  // reset, then wait a bounded time for the boot capture
  task automatic do_reset;
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    sel_m = 16'h003c;
    for (cnt = 0; cnt < 30; cnt++) begin
      @(negedge clk_in);
      if (boot_valid_out === 1'b1) break;
      chk_reg({12'h0, addr_pin_oe_n_out}, 16'h000f);
    end
    if (cnt >= 30) begin
      n_errors++;
      summarize();
    end
    chk_reg({15'h0, cnt >= 10 && cnt <= 16}, 16'h0001);
    chk_reg({12'h0, boot_level_out}, {12'h0, ext_q[15:12]});
    rd(16'h1c00, d);
    chk_reg(d, sel_m[15:0]);
  endtask
  ////////////////////
  initial begin
    rnd_q = 32'h0a89;
    {resetn_in, reg_wr_in, reg_rd_in, gate_q} = 4'h0;
    {reg_addr_in, reg_wdata_in, ext_q} = {32'h0, 16'ha5c3};
    {n_errors, checks_done} = {32'h0, 32'h0};
    do_reset();
    // every route pair, random address modes and reserved bits
    for (int i = 0; i < 16; i++) begin
      w = rnd_q[31:16];
      w[11:8] = i[3:0];
      @(posedge clk_in);
      gate_q <= 1'b1;
      wr(16'h1c00, w);
      gate_q <= 1'b0;
      repeat (3) begin
        @(negedge clk_in);
        chk_pin({sp1_pin_out, sp1_pin_oe_n_out, sp0_pin_out, sp0_pin_oe_n_out, addr_pin_out,
          addr_pin_oe_n_out}, exp_pins(sel_m));
        chk_pin({card1_in_out, mcsm_in_out, card0_in_out, aud0_in_out, bms_in_out, gio_in_out},
          exp_lvl(sel_m, ph2));
      end
      rd(16'h1c00, d);
      chk_reg(d, sel_m[15:0]);
    end
    // unmapped and read-only places leave everything alone
    wr(16'h1c01, 16'hffff);
    wr(16'h1c07, 16'h0000);
    rd(16'h1c01, d);
    chk_reg(d, {12'h0, ext_q[15:12]});
    rd(16'h1c07, d);
    chk_reg(d, 16'h0000);
    rd(16'h1c00, d);
    chk_reg(d, sel_m[15:0]);
    // second reset in mid-run with new outside levels
    ext_q <= rnd_q[15:0];
    do_reset();
    summarize();
  end
endmodule // spmx_tb_top

`default_nettype wire
